// >>> wdr_pkg.sv
// Package with register map, field layouts, reset values and timing counts.
package wdr_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [1:0] ADDR_WDOG_CTRL = 2'h0;
	localparam logic [1:0] ADDR_RST_FLAGS = 2'h1;
	localparam logic [1:0] ADDR_VSEL      = 2'h2;
	localparam logic [1:0] ADDR_PWR_STAT  = 2'h3;
	// ==========================================================
	// Reset values and keyed codes
	localparam logic [7:0] WDOG_CTRL_POR  = 8'h53;
	localparam logic [7:0] VSEL_POR       = 8'h55;
	localparam logic [4:0] KEY_DISABLE    = 5'h15;
	localparam logic [4:0] KEY_ENABLE     = 5'h0A;
	localparam logic [7:0] VSEL_2V10      = 8'h55;
	localparam logic [7:0] VSEL_2V55      = 8'h33;
	localparam logic [7:0] VSEL_3V15      = 8'h99;
	localparam logic [7:0] VSEL_3V80      = 8'hAA;
	// ==========================================================
	// Field positions in the reset cause register
	localparam int FLAG_WDOG_CTRL = 0;
	localparam int FLAG_VSEL      = 1;
	localparam int FLAG_LOW_VOLT  = 2;
	localparam int FLAG_SYSCLK_ON = 7;
	// Field positions in the power status register
	localparam int STAT_POWER_DOWN = 0;
	localparam int STAT_TIMEOUT    = 1;
	// ==========================================================
	// Timing
	localparam int CNT_WIDTH        = 18;
	localparam logic [1:0] KEY_RST_DELAY = 2'h2;
	localparam int LV_QUAL_CYCLES   = 4;
	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_PEND  = 3'b010,
		ST_RESET = 3'b100
	} wdr_state_e;
endpackage

// >>> wdr_low_voltage_filter.sv
// Qualifying filter for the low supply indication.
`timescale 1ns/1ps
`default_nettype none
module wdr_low_voltage_filter #(
	parameter int QUAL = 4
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic lowSupply,
	input  wire logic enable,
	output logic      qualified
);
	logic [7:0] count;
	logic [7:0] next_count;
	logic       next_qualified;

	// ==========================================================
	// Dip length counter
	// Short dips restart the count, so only a sustained low fires.
	always_comb begin
		next_count     = 8'h00;
		next_qualified = 1'b0;
		if (enable && lowSupply) begin
			if (count == 8'(QUAL)) begin
				next_count     = count;
				next_qualified = 1'b1;
			end else begin
				next_count = count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count     <= 8'h00;
			qualified <= 1'b0;
		end else begin
			count     <= next_count;
			qualified <= next_qualified;
		end
	end
endmodule
`default_nettype wire

// >>> wdr_watchdog_and_reset_control.sv
// Watchdog timer, keyed enable, voltage select and reset cause logic.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module wdr_watchdog_and_reset_control
	import wdr_pkg::*;
#(
	parameter int CW   = wdr_pkg::CNT_WIDTH,
	parameter int QUAL = wdr_pkg::LV_QUAL_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       powerOnRst,
	input  wire logic       subTick,
	input  wire logic       clearWatchdogInstr,
	input  wire logic       haltInstr,
	input  wire logic       haltDeepest,
	input  wire logic       powerDown,
	input  wire logic       lowSupply,
	input  wire logic [1:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdData,
	output logic            deviceReset,
	output logic            pcStackReset,
	output logic            portsToInputs,
	output logic            pcToZero,
	output logic            timeoutEvent
);
	import wdr_pkg::*;

	logic [7:0]       wdogCtrl, next_wdogCtrl;
	logic [7:0]       vsel, next_vsel;
	logic [2:0]       flags, next_flags;
	logic             sysclkKeepOn, next_sysclkKeepOn;
	logic             timeoutFlag, next_timeoutFlag;
	logic             powerDownFlag, next_powerDownFlag;
	logic [CW-1:0]    wdCount, next_wdCount;
	logic             sleeping, next_sleeping;
	wdr_state_e       keyState, next_keyState;
	wdr_state_e       vselState, next_vselState;
	logic [1:0]       keyDelay, next_keyDelay;
	logic [1:0]       vselDelay, next_vselDelay;
	logic [7:0]       next_regRdData;
	logic             next_deviceReset, next_pcStackReset, next_timeout;
	logic [CW-1:0]    limit;
	logic             keyBad, vselBad, wdEnabled, lvFire, wrCtrl, wrVsel;
	logic             keyFire, vselFire;

	// ==========================================================
	// Decodes
	assign wrCtrl   = regWrite && (regAddr == ADDR_WDOG_CTRL);
	assign wrVsel   = regWrite && (regAddr == ADDR_VSEL);
	assign wdEnabled = (wdogCtrl[7:3] == KEY_ENABLE);
	assign keyBad   = !wdEnabled && (wdogCtrl[7:3] != KEY_DISABLE);
	assign vselBad  = !(vsel == VSEL_2V10 || vsel == VSEL_2V55 ||
	                    vsel == VSEL_3V15 || vsel == VSEL_3V80);
	assign keyFire  = (keyState == ST_RESET);
	assign vselFire = (vselState == ST_RESET);

	// Period code to terminal count.
	always_comb begin
		case (wdogCtrl[2:0])
			3'h0:    limit = CW'(18'h000FF);
			3'h1:    limit = CW'(18'h003FF);
			3'h2:    limit = CW'(18'h00FFF);
			3'h3:    limit = CW'(18'h03FFF);
			3'h4:    limit = CW'(18'h07FFF);
			3'h5:    limit = CW'(18'h0FFFF);
			3'h6:    limit = CW'(18'h1FFFF);
			default: limit = CW'(18'h3FFFF);
		endcase
	end

	// ==========================================================
	// Low voltage qualification
	wdr_low_voltage_filter #(
		.QUAL(QUAL)
	) u_filter (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.lowSupply(lowSupply),
		.enable   (!powerDown),
		.qualified(lvFire)
	);

	// ==========================================================
	// Illegal code delay machines
	// The delay counts low speed ticks so the reset lands one to two
	// slow cycles later, depending on where the first tick falls.
	always_comb begin
		next_keyState  = keyState;
		next_keyDelay  = keyDelay;
		next_vselState = vselState;
		next_vselDelay = vselDelay;
		case (keyState)
			ST_RUN: begin
				if (keyBad) begin
					next_keyState = ST_PEND;
					next_keyDelay = 2'h0;
				end
			end
			ST_PEND: begin
				if (subTick) begin
					next_keyDelay = keyDelay + 2'h1;
				end
				if (subTick && keyDelay == KEY_RST_DELAY - 2'h1) begin
					next_keyState = ST_RESET;
				end
			end
			ST_RESET: next_keyState = ST_RUN;
			default:  next_keyState = ST_RUN;
		endcase
		case (vselState)
			ST_RUN: begin
				if (vselBad) begin
					next_vselState = ST_PEND;
					next_vselDelay = 2'h0;
				end
			end
			ST_PEND: begin
				if (subTick) begin
					next_vselDelay = vselDelay + 2'h1;
				end
				if (subTick && vselDelay == KEY_RST_DELAY - 2'h1) begin
					next_vselState = ST_RESET;
				end
			end
			ST_RESET: next_vselState = ST_RUN;
			default:  next_vselState = ST_RUN;
		endcase
	end

	// ==========================================================
	// Watchdog counter and reset generation
	always_comb begin
		next_wdCount      = wdCount;
		next_sleeping     = sleeping;
		next_timeout      = 1'b0;
		next_deviceReset  = 1'b0;
		next_pcStackReset = 1'b0;
		if (keyFire || clearWatchdogInstr || haltInstr) begin
			next_wdCount = '0;
		end else if (haltDeepest) begin
			next_wdCount = '0;
		end else if (wdEnabled && subTick) begin
			if (wdCount == limit) begin
				next_wdCount = '0;
				next_timeout = 1'b1;
			end else begin
				next_wdCount = wdCount + CW'(1);
			end
		end
		if (haltInstr) begin
			next_sleeping = 1'b1;
		end
		if (timeoutEvent || keyFire || vselFire || lvFire) begin
			next_sleeping = 1'b0;
		end
		if (timeoutEvent && sleeping) begin
			next_pcStackReset = 1'b1;
		end else if (timeoutEvent || keyFire || vselFire || lvFire) begin
			next_deviceReset = 1'b1;
		end
	end

	// ==========================================================
	// Registers, flags and read path
	always_comb begin
		next_wdogCtrl      = wdogCtrl;
		next_vsel          = vsel;
		next_flags         = flags;
		next_sysclkKeepOn  = sysclkKeepOn;
		next_timeoutFlag   = timeoutFlag;
		next_powerDownFlag = powerDownFlag;
		next_regRdData     = 8'h00;
		if (wrCtrl) begin
			next_wdogCtrl = regWrData;
		end
		if (wrVsel) begin
			next_vsel = regWrData;
		end
		if (regWrite && regAddr == ADDR_RST_FLAGS) begin
			// Software may write either value; hardware set wins below.
			next_flags        = regWrData[2:0];
			next_sysclkKeepOn = regWrData[FLAG_SYSCLK_ON];
		end
		if (clearWatchdogInstr) begin
			next_powerDownFlag = 1'b0;
			next_timeoutFlag   = 1'b0;
		end
		if (haltInstr) begin
			next_powerDownFlag = 1'b1;
			next_timeoutFlag   = 1'b0;
		end
		if (vselFire) begin
			next_vsel = VSEL_POR;
			next_flags[FLAG_VSEL] = 1'b1;
		end
		// The select register is left alone on a genuine dip.
		if (lvFire) begin
			next_flags[FLAG_LOW_VOLT] = 1'b1;
		end
		if (keyFire) begin
			next_flags[FLAG_WDOG_CTRL] = 1'b1;
		end
		if (timeoutEvent) begin
			next_timeoutFlag = 1'b1;
		end
		if (regRead) begin
			case (regAddr)
				ADDR_WDOG_CTRL: next_regRdData = wdogCtrl;
				ADDR_RST_FLAGS: next_regRdData = {sysclkKeepOn, 4'h0,
				                                  flags};
				ADDR_VSEL:      next_regRdData = vsel;
				default:        next_regRdData = {6'h00, timeoutFlag,
				                                  powerDownFlag};
			endcase
		end
	end

	// Power on reset restores everything but the low voltage filter, which only sys_rst clears; sys_rst is the same event here.
	always_ff @(posedge clk) begin
		if (sys_rst || powerOnRst) begin
			wdogCtrl      <= WDOG_CTRL_POR;
			vsel          <= VSEL_POR;
			flags         <= 3'h0;
			sysclkKeepOn  <= 1'b0;
			timeoutFlag   <= 1'b0;
			powerDownFlag <= 1'b0;
			wdCount       <= '0;
			sleeping      <= 1'b0;
			keyState      <= ST_RUN;
			vselState     <= ST_RUN;
			keyDelay      <= 2'h0;
			vselDelay     <= 2'h0;
			regRdData     <= 8'h00;
			deviceReset   <= 1'b0;
			pcStackReset  <= 1'b0;
			timeoutEvent  <= 1'b0;
			portsToInputs <= 1'b1;
			pcToZero      <= 1'b1;
		end else begin
			wdogCtrl      <= next_wdogCtrl;
			vsel          <= next_vsel;
			flags         <= next_flags;
			sysclkKeepOn  <= next_sysclkKeepOn;
			timeoutFlag   <= next_timeoutFlag;
			powerDownFlag <= next_powerDownFlag;
			wdCount       <= next_wdCount;
			sleeping      <= next_sleeping;
			keyState      <= next_keyState;
			vselState     <= next_vselState;
			keyDelay      <= next_keyDelay;
			vselDelay     <= next_vselDelay;
			regRdData     <= next_regRdData;
			deviceReset   <= next_deviceReset;
			pcStackReset  <= next_pcStackReset;
			timeoutEvent  <= next_timeout;
			portsToInputs <= next_deviceReset;
			pcToZero      <= next_deviceReset || next_pcStackReset;
		end
	end
endmodule
`default_nettype wire

// >>> wdr_watchdog_chk.sv
// Port timing checker for the watchdog and reset block.
`timescale 1ns/1ps
`default_nettype none
module wdr_watchdog_chk
	import wdr_pkg::*;
(
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       powerOnRst,
	input wire logic       haltDeepest,
	input wire logic       powerDown,
	input wire logic       lowSupply,
	input wire logic [1:0] regAddr,
	input wire logic       regRead,
	input wire logic [7:0] regRdData,
	input wire logic       deviceReset,
	input wire logic       pcStackReset,
	input wire logic       portsToInputs,
	input wire logic       pcToZero,
	input wire logic       timeoutEvent
);
	// ====================================
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_gaps;
		regRead && regAddr == ADDR_RST_FLAGS |=> regRdData[6:3] == 4'h0;
	endproperty
	a_gaps: assert property (p_gaps)
		else $error("Flag gap bits read nonzero.");
	property p_to_rst; timeoutEvent |=> deviceReset || pcStackReset; endproperty
	a_to_rst: assert property (p_to_rst)
		else $error("Timeout without reset.");
	property p_to_once; timeoutEvent |=> !timeoutEvent; endproperty
	a_to_once: assert property (p_to_once)
		else $error("Timeout longer than one cycle.");
	property p_por; powerOnRst |=> portsToInputs && pcToZero; endproperty
	a_por: assert property (p_por)
		else $error("Power-on reset missed ports or counter.");
	property p_dev; deviceReset |-> portsToInputs && pcToZero; endproperty
	a_dev: assert property (p_dev)
		else $error("Full reset missed ports or counter.");
	property p_pcs; pcStackReset |-> pcToZero && !portsToInputs; endproperty
	a_pcs: assert property (p_pcs)
		else $error("Sleep reset touched ports.");
	property p_deep; haltDeepest [*2] |-> !timeoutEvent; endproperty
	a_deep: assert property (p_deep)
		else $error("Timeout in deepest sleep.");
	property p_lv; (lowSupply && !powerDown) [*8] |-> deviceReset; endproperty
	a_lv: assert property (p_lv)
		else $error("Held low supply gave no reset.");
endmodule
bind wdr_watchdog_and_reset_control wdr_watchdog_chk u_chk (.*);
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the watchdog and reset block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import wdr_pkg::*;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       powerOnRst = 1'b0;
	logic       subTick = 1'b0;
	logic       clearWatchdogInstr = 1'b0;
	logic       haltInstr = 1'b0;
	logic       haltDeepest = 1'b0;
	logic       powerDown = 1'b0;
	logic       lowSupply = 1'b0;
	logic [1:0] regAddr = 2'h0;
	logic [7:0] regWrData = 8'h00;
	logic       regWrite = 1'b0;
	logic       regRead = 1'b0;
	logic [7:0] regRdData;
	logic       deviceReset;
	logic       pcStackReset;
	logic       portsToInputs;
	logic       pcToZero;
	logic       timeoutEvent;
	logic [7:0] d;
	int         devs = 0;
	int         pcs = 0;
	int         tos = 0;
	int         cyc = 0;
	int         n;
	int         m;
	int         mismatches = 0;
	int         tests_run = 0;
	localparam int EXPO[4] = '{8, 10, 12, 14};
	localparam logic [7:0] VCODE[4] =
		'{VSEL_2V10, VSEL_2V55, VSEL_3V15, VSEL_3V80};
	wdr_watchdog_and_reset_control dut (.*);
	// ====================================
	// Clock, pulse tallies and bus tasks
	always #5 clk = ~clk;
	// Tallies move on the falling edge so they never race the drivers.
	always @(negedge clk) begin
		devs += int'(deviceReset);
		pcs += int'(pcStackReset);
		tos += int'(timeoutEvent);
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wreg(logic [1:0] a, logic [7:0] v);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rreg(logic [1:0] a);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		d = regRdData;
		@(posedge clk);
	endtask
	task automatic tick(int k);
		repeat (k) begin
			subTick <= 1'b1;
			@(posedge clk);
			subTick <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic instr(logic h);
		clearWatchdogInstr <= !h;
		haltInstr <= h;
		@(posedge clk);
		clearWatchdogInstr <= 1'b0;
		haltInstr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ====================================
	// Scenarios
	task automatic t_regs();
		powerOnRst <= 1'b1;
		@(posedge clk);
		powerOnRst <= 1'b0;
		@(negedge clk);
		chk("ports to inputs", 8'(portsToInputs), 8'h01);
		chk("pc to zero", 8'(pcToZero), 8'h01);
		@(posedge clk);
		rreg(ADDR_WDOG_CTRL);
		chk("watchdog_control", d, WDOG_CTRL_POR);
		rreg(ADDR_VSEL);
		chk("low_voltage_select", d, VSEL_POR);
		wreg(ADDR_PWR_STAT, 8'hFF);
		rreg(ADDR_PWR_STAT);
		chk("status", d, 8'h00);
		wreg(ADDR_RST_FLAGS, 8'hFF);
		rreg(ADDR_RST_FLAGS);
		chk("flag gaps", d, 8'h87);
		wreg(ADDR_RST_FLAGS, 8'h00);
	endtask
	task automatic t_wdog();
		for (int c = 0; c < 4; c++) begin
			wreg(ADDR_WDOG_CTRL, {KEY_ENABLE, 3'(c)});
			instr(1'b0);
			n = tos;
			m = devs;
			tick((1 << EXPO[c]) - 1);
			chk("early timeout", 8'(tos - n), 8'h00);
			tick(1);
			repeat (3) @(posedge clk);
			chk("timeout", 8'(tos - n), 8'h01);
			chk("full reset", 8'(devs - m), 8'h01);
		end
		rreg(ADDR_PWR_STAT);
		chk("timeout flag", d & 8'h02, 8'h02);
	endtask
	task automatic t_clear();
		wreg(ADDR_WDOG_CTRL, {KEY_ENABLE, 3'h0});
		instr(1'b0);
		n = tos;
		tick(200);
		instr(1'b0);
		tick(255);
		chk("cleared count", 8'(tos - n), 8'h00);
		instr(1'b1);
		tick(255);
		chk("halted count", 8'(tos - n), 8'h00);
		m = devs;
		n = pcs;
		tick(1);
		repeat (3) @(posedge clk);
		chk("sleep pc reset", 8'(pcs - n), 8'h01);
		chk("sleep full reset", 8'(devs - m), 8'h00);
		rreg(ADDR_PWR_STAT);
		chk("sleep flags", d, 8'h03);
	endtask
	task automatic t_key();
		wreg(ADDR_WDOG_CTRL, {KEY_DISABLE, 3'h0});
		n = tos;
		tick(300);
		chk("disabled timeout", 8'(tos - n), 8'h00);
		m = devs;
		wreg(ADDR_WDOG_CTRL, 8'hF8);
		tick(1);
		chk("early key reset", 8'(devs - m), 8'h00);
		tick(2);
		wreg(ADDR_WDOG_CTRL, {KEY_DISABLE, 3'h0});
		chk("key reset", 8'(devs - m), 8'h01);
		// The field was still illegal when the machine re-armed, so one more
		// reset is owed even though the code is now legal.
		tick(2);
		@(posedge clk);
		chk("rearmed key reset", 8'(devs - m), 8'h02);
		rreg(ADDR_RST_FLAGS);
		chk("key flag", d, 8'h01);
		wreg(ADDR_RST_FLAGS, 8'h00);
		rreg(ADDR_RST_FLAGS);
		chk("key flag cleared", d, 8'h00);
	endtask
	task automatic t_vsel();
		m = devs;
		for (int i = 0; i < 4; i++) begin
			wreg(ADDR_VSEL, VCODE[i]);
			tick(4);
			rreg(ADDR_VSEL);
			chk("legal select", d, VCODE[i]);
		end
		chk("legal select reset", 8'(devs - m), 8'h00);
		wreg(ADDR_VSEL, 8'h12);
		tick(3);
		rreg(ADDR_VSEL);
		chk("restored select", d, VSEL_POR);
		chk("select reset", 8'(devs - m), 8'h01);
		rreg(ADDR_RST_FLAGS);
		chk("select flag", d, 8'h02);
		wreg(ADDR_RST_FLAGS, 8'h00);
	endtask
	task automatic t_lv();
		wreg(ADDR_VSEL, VSEL_3V15);
		m = devs;
		lowSupply <= 1'b1;
		repeat (3) @(posedge clk);
		lowSupply <= 1'b0;
		powerDown <= 1'b1;
		@(posedge clk);
		lowSupply <= 1'b1;
		repeat (12) @(posedge clk);
		lowSupply <= 1'b0;
		repeat (3) @(posedge clk);
		chk("filtered reset", 8'(devs - m), 8'h00);
		powerDown <= 1'b0;
		lowSupply <= 1'b1;
		repeat (10) @(posedge clk);
		lowSupply <= 1'b0;
		rreg(ADDR_VSEL);
		chk("kept select", d, VSEL_3V15);
		chk("lv reset", 8'(devs > m), 8'h01);
		rreg(ADDR_RST_FLAGS);
		chk("lv flag", d, 8'h04);
		wreg(ADDR_RST_FLAGS, 8'h00);
		rreg(ADDR_RST_FLAGS);
		chk("lv flag cleared", d, 8'h00);
	endtask
	task automatic t_deep();
		wreg(ADDR_WDOG_CTRL, {KEY_ENABLE, 3'h0});
		haltDeepest <= 1'b1;
		n = tos;
		tick(300);
		haltDeepest <= 1'b0;
		wreg(ADDR_WDOG_CTRL, {KEY_DISABLE, 3'h0});
		chk("deep sleep timeout", 8'(tos - n), 8'h00);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_wdog();
		t_clear();
		t_key();
		t_vsel();
		t_lv();
		t_deep();
		stop_test();
	end
endmodule
`default_nettype wire
